// ### startup_boot_pkg.sv
package startup_boot_pkg;
  // Register offsets on the slave port, 1 KiB decode window
  localparam logic [9:0] OFF_BOOT_RETRY_SOURCE = 10'h000;
  localparam logic [9:0] OFF_EEPROM_TARGET = 10'h001;
  localparam logic [9:0] OFF_REV_PART_HIGH = 10'h002;
  localparam logic [9:0] OFF_PART_MIDDLE = 10'h003;
  localparam logic [9:0] OFF_PART_LOW_CFG_HIGH = 10'h004;
  localparam logic [9:0] OFF_CFG_LOW = 10'h005;
  localparam logic [9:0] OFF_INT_ENABLE = 10'h079;
  localparam logic [9:0] OFF_GPI_STATUS = 10'h20C;
  localparam logic [9:0] OFF_GLOBAL_STATUS = 10'h210;
  // Field positions
  localparam int POS_SKIP_EXT = 0;
  localparam int POS_SKIP_INT = 1;
  localparam int POS_WIDE = 7;
  localparam int POS_BOOT_FAIL = 0;
  localparam int POS_BOOT_DONE = 1;
  localparam int POS_SPEED = 0;
  // Reset values before the factory image is captured
  localparam logic [4:0] RST_RETRY = 5'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Serial memory layout
  localparam logic [7:0] EE_FIRST = 8'h00;
  localparam logic [7:0] EE_SPEED = 8'h05;
  localparam logic [7:0] EE_REG_FIRST = 8'h08;
  localparam logic [7:0] EE_REG_LAST = 8'h83;
  localparam logic [7:0] EE_CRC = 8'h84;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [2:0] {
    ST_WAIT_POR = 3'b000,
    ST_CAPTURE = 3'b001,
    ST_DECIDE = 3'b010,
    ST_REQUEST = 3'b011,
    ST_READY = 3'b100
  } boot_state_e;
endpackage

// ### startup_boot_and_id_registers.sv
`timescale 1ns/100ps
module startup_boot_and_id_registers
  import startup_boot_pkg::*;
#(
  parameter logic [3:0] REVISION_DEFAULT = 4'h5, // Arbitrary neutral value
  parameter logic [15:0] PART_CODE_DEFAULT = 16'hA5C3 // Arbitrary neutral value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_done_i,
  input wire logic [7:0] otp_startup0_i,
  input wire logic [7:0] otp_startup1_i,
  input wire logic [10:0] otp_config_code_i,
  input wire logic [7:0] gpi_status_i,
  input wire logic [7:0] global_status_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ready_o,
  output logic mst_req_o,
  output logic [6:0] mst_dev_addr_o,
  output logic mst_wide_o,
  output logic [14:0] mst_offset_o,
  output logic mst_fast_o,
  input wire logic mst_done_i,
  input wire logic mst_nack_i,
  input wire logic mst_arb_lost_i,
  input wire logic [7:0] mst_data_i,
  output logic load_wr_o,
  output logic [7:0] load_addr_o,
  output logic [7:0] load_data_o,
  output logic otp_full_load_o,
  output logic boot_busy_o,
  output logic boot_failure_flag_o,
  output logic [7:0] int_enable_o
);

  boot_state_e state, next_state;
  logic [4:0] boot_retry_count, next_boot_retry_count;
  logic skip_full_internal_load, next_skip_full_internal_load;
  logic skip_external_boot, next_skip_external_boot;
  logic memory_wide_offset, next_memory_wide_offset;
  logic [6:0] memory_bus_address, next_memory_bus_address;
  logic [3:0] revision_field, next_revision_field;
  logic [15:0] part_code_field, next_part_code_field;
  logic [10:0] config_code, next_config_code;
  logic [7:0] int_enable, next_int_enable;
  logic [4:0] retries_used, next_retries_used;
  logic [7:0] byte_offset, next_byte_offset;
  logic [7:0] crc, next_crc;
  logic fast, next_fast;
  logic boot_failure_flag, next_boot_failure_flag;
  logic [7:0] rdata, next_rdata;
  logic load_wr, next_load_wr;
  logic [7:0] load_addr, next_load_addr;
  logic [7:0] load_data, next_load_data;
  logic access_ok;
  logic fail_clear;

  // CRC-8 with polynomial x^8+x^2+x+1, MSB first
  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Slave accesses are only honoured once loading has finished
  assign access_ok = (state == ST_READY);
  assign fail_clear = access_ok && reg_wr_i && (reg_addr_i == OFF_GLOBAL_STATUS)
    && reg_wdata_i[POS_BOOT_FAIL];

  // Boot sequencer and register file next values
  always_comb begin
    next_state = state;
    next_boot_retry_count = boot_retry_count;
    next_skip_full_internal_load = skip_full_internal_load;
    next_skip_external_boot = skip_external_boot;
    next_memory_wide_offset = memory_wide_offset;
    next_memory_bus_address = memory_bus_address;
    next_revision_field = revision_field;
    next_part_code_field = part_code_field;
    next_config_code = config_code;
    next_int_enable = int_enable;
    next_retries_used = retries_used;
    next_byte_offset = byte_offset;
    next_crc = crc;
    next_fast = fast;
    next_boot_failure_flag = boot_failure_flag;
    next_rdata = rdata;
    next_load_wr = 1'b0;
    next_load_addr = load_addr;
    next_load_data = load_data;
    if (fail_clear) begin
      next_boot_failure_flag = 1'b0;
    end
    unique case (state)
      ST_WAIT_POR: begin
        if (por_done_i) begin
          next_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        // Factory image taken after reset release, never as a reset value
        next_skip_external_boot = otp_startup0_i[POS_SKIP_EXT];
        next_skip_full_internal_load = otp_startup0_i[POS_SKIP_INT];
        next_memory_wide_offset = otp_startup1_i[POS_WIDE];
        next_memory_bus_address = otp_startup1_i[6:0];
        next_config_code = otp_config_code_i;
        next_state = ST_DECIDE;
      end
      ST_DECIDE: begin
        next_byte_offset = EE_FIRST;
        next_crc = CRC_INIT;
        next_retries_used = 5'h00;
        next_fast = 1'b0;
        next_state = skip_external_boot ? ST_READY : ST_REQUEST;
      end
      ST_REQUEST: begin
        if (mst_done_i) begin
          if (mst_arb_lost_i) begin
            if (retries_used < boot_retry_count) begin
              next_retries_used = retries_used + 5'h01;
            end else begin
              next_boot_failure_flag = 1'b1;
              next_state = ST_READY;
            end
          end else if (mst_nack_i) begin
            next_boot_failure_flag = 1'b1;
            next_state = ST_READY;
          end else if (byte_offset == EE_CRC) begin
            next_boot_failure_flag = (mst_data_i != crc);
            next_state = ST_READY;
          end else begin
            next_crc = crc8_step(crc, mst_data_i);
            next_byte_offset = byte_offset + 8'h01;
            next_retries_used = 5'h00;
            if (byte_offset == EE_SPEED) begin
              next_fast = mst_data_i[POS_SPEED];
            end
            // Device registers above the startup block are streamed out
            if (byte_offset >= EE_REG_FIRST && byte_offset <= EE_REG_LAST) begin
              next_load_wr = 1'b1;
              next_load_addr = byte_offset;
              next_load_data = mst_data_i;
            end
          end
        end
      end
      ST_READY: begin
        // Writes only store; the sequencer never leaves this state until reset
        if (reg_rd_i) begin
          unique case (reg_addr_i)
            OFF_BOOT_RETRY_SOURCE: next_rdata = {boot_retry_count, 1'b0,
              skip_full_internal_load, skip_external_boot};
            OFF_EEPROM_TARGET: next_rdata = {memory_wide_offset, memory_bus_address};
            OFF_REV_PART_HIGH: next_rdata = {revision_field, part_code_field[15:12]};
            OFF_PART_MIDDLE: next_rdata = part_code_field[11:4];
            OFF_PART_LOW_CFG_HIGH: next_rdata = {part_code_field[3:0], config_code[10:7]};
            OFF_CFG_LOW: next_rdata = {1'b0, config_code[6:0]};
            OFF_INT_ENABLE: next_rdata = int_enable;
            OFF_GPI_STATUS: next_rdata = gpi_status_i;
            OFF_GLOBAL_STATUS: next_rdata = {global_status_i[7:2], 1'b1,
              boot_failure_flag};
            default: next_rdata = RST_BYTE; // Unowned or reserved offsets read zero
          endcase
        end
        if (reg_wr_i) begin
          unique case (reg_addr_i)
            OFF_BOOT_RETRY_SOURCE: begin
              next_boot_retry_count = reg_wdata_i[7:3];
              next_skip_full_internal_load = reg_wdata_i[POS_SKIP_INT];
              next_skip_external_boot = reg_wdata_i[POS_SKIP_EXT];
            end
            OFF_EEPROM_TARGET: begin
              next_memory_wide_offset = reg_wdata_i[POS_WIDE];
              next_memory_bus_address = reg_wdata_i[6:0];
            end
            OFF_REV_PART_HIGH: begin
              next_revision_field = reg_wdata_i[7:4];
              next_part_code_field[15:12] = reg_wdata_i[3:0];
            end
            OFF_PART_MIDDLE: next_part_code_field[11:4] = reg_wdata_i;
            OFF_PART_LOW_CFG_HIGH: begin
              next_part_code_field[3:0] = reg_wdata_i[7:4];
              next_config_code[10:7] = reg_wdata_i[3:0];
            end
            OFF_CFG_LOW: next_config_code[6:0] = reg_wdata_i[6:0];
            OFF_INT_ENABLE: next_int_enable = reg_wdata_i;
            default: ;
          endcase
        end
      end
      default: next_state = ST_WAIT_POR;
    endcase
  end

  // State registers; reset values are constants only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_WAIT_POR;
      boot_retry_count <= RST_RETRY;
      skip_full_internal_load <= 1'b1;
      skip_external_boot <= 1'b1;
      memory_wide_offset <= 1'b0;
      memory_bus_address <= 7'h00;
      revision_field <= REVISION_DEFAULT;
      part_code_field <= PART_CODE_DEFAULT;
      config_code <= 11'h000;
      int_enable <= RST_BYTE;
      retries_used <= 5'h00;
      byte_offset <= EE_FIRST;
      crc <= CRC_INIT;
      fast <= 1'b0;
      boot_failure_flag <= 1'b0;
      rdata <= RST_BYTE;
      load_wr <= 1'b0;
      load_addr <= RST_BYTE;
      load_data <= RST_BYTE;
    end else begin
      state <= next_state;
      boot_retry_count <= next_boot_retry_count;
      skip_full_internal_load <= next_skip_full_internal_load;
      skip_external_boot <= next_skip_external_boot;
      memory_wide_offset <= next_memory_wide_offset;
      memory_bus_address <= next_memory_bus_address;
      revision_field <= next_revision_field;
      part_code_field <= next_part_code_field;
      config_code <= next_config_code;
      int_enable <= next_int_enable;
      retries_used <= next_retries_used;
      byte_offset <= next_byte_offset;
      crc <= next_crc;
      fast <= next_fast;
      boot_failure_flag <= next_boot_failure_flag;
      rdata <= next_rdata;
      load_wr <= next_load_wr;
      load_addr <= next_load_addr;
      load_data <= next_load_data;
    end
  end

  // Master request held until the engine reports completion
  assign mst_req_o = (state == ST_REQUEST);
  assign mst_dev_addr_o = memory_bus_address;
  assign mst_wide_o = memory_wide_offset;
  assign mst_offset_o = {7'h00, byte_offset};
  assign mst_fast_o = fast;
  assign reg_rdata_o = rdata;
  assign reg_ready_o = access_ok;
  assign load_wr_o = load_wr;
  assign load_addr_o = load_addr;
  assign load_data_o = load_data;
  // Only the first eight bytes come from the store when the skip bit is set
  assign otp_full_load_o = ~skip_full_internal_load;
  assign boot_busy_o = ~access_ok;
  assign boot_failure_flag_o = boot_failure_flag;
  assign int_enable_o = int_enable;

endmodule // startup_boot_and_id_registers

// ### startup_boot_sva.sv
`timescale 1ns/100ps
module startup_boot_sva
  import startup_boot_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_done_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_ready_o,
  input wire logic boot_busy_o,
  input wire logic mst_req_o,
  input wire logic [14:0] mst_offset_o,
  input wire logic mst_fast_o,
  input wire logic mst_done_i,
  input wire logic mst_nack_i,
  input wire logic mst_arb_lost_i,
  input wire logic [7:0] mst_data_i,
  input wire logic load_wr_o,
  input wire logic [7:0] load_addr_o,
  input wire logic [7:0] load_data_o,
  input wire logic boot_failure_flag_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Ordering of boot and slave service
  AST_NO_MASTER_READY: assert property (reg_ready_o |-> !mst_req_o)
    else $error("bus request while slave port ready");
  AST_WAIT_POR: assert property (!por_done_i |-> boot_busy_o && !mst_req_o)
    else $error("activity before power-up done");
  AST_READY_STAYS: assert property (reg_ready_o |=> reg_ready_o)
    else $error("loading restarted after ready");
  // Byte requests: held, retried in place, stepped only on a good byte
  AST_REQ_HOLD: assert property (mst_req_o && !mst_done_i |=> mst_req_o && $stable(mst_offset_o))
    else $error("request dropped or moved before done");
  AST_RETRY_SAME: assert property (mst_done_i && mst_arb_lost_i |=> $stable(mst_offset_o))
    else $error("offset moved after lost arbitration");
  AST_STEP: assert property (mst_done_i && !mst_nack_i && !mst_arb_lost_i && mst_offset_o < 15'h84
    |=> mst_offset_o == $past(mst_offset_o) + 15'h1)
    else $error("offset did not step by one");
  AST_END: assert property (mst_done_i && (mst_offset_o == 15'h84 || mst_nack_i) |-> ##[1:2] !mst_req_o)
    else $error("request still high after last byte");
  // Loaded bytes mirror the accepted memory bytes
  AST_LOAD: assert property (load_wr_o |-> $past(mst_done_i) && {7'h00, load_addr_o} == $past(mst_offset_o)
    && load_data_o == $past(mst_data_i) && load_addr_o inside {[8'h08:8'h83]})
    else $error("load stream byte mismatch");
  AST_SLOW: assert property ($rose(mst_req_o) |-> !mst_fast_o)
    else $error("boot did not start at low speed");
  AST_FAST: assert property (mst_done_i && mst_offset_o == 15'h5 && !mst_arb_lost_i
    |=> mst_fast_o == |($past(mst_data_i) & 8'h01))
    else $error("speed bit not taken from byte 05");
  AST_FAIL_STICKY: assert property (boot_failure_flag_o && !(reg_wr_i && reg_ready_o
    && reg_addr_i == OFF_GLOBAL_STATUS && reg_wdata_i[0]) |=> boot_failure_flag_o)
    else $error("failure flag lost without clear");
endmodule // startup_boot_sva

bind startup_boot_and_id_registers startup_boot_sva chk (.*);

// ### boot_memory_model.sv
`timescale 1ns/100ps
module boot_memory_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [14:0] offset_i,
  input wire logic slow_i,
  input wire logic bad_crc_i,
  input wire logic [1:0] arb_loss_i,
  input wire logic nack_i,
  output logic done_o,
  output logic nack_o,
  output logic arb_lost_o,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:132];
  logic [7:0] crc;
  logic [2:0] wait_cnt;
  logic [1:0] lost;

  // Image with byte 05 bit 0 set and its checksum in the last byte
  initial begin
    crc = 8'h00;
    for (int i = 0; i < 132; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
      crc = crc ^ mem[i];
      for (int b = 0; b < 8; b++) crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
    end
    mem[132] = crc;
  end

  // Answers each byte after a short or long wait; idle data toggles, never stale
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt <= 3'h0;
      lost <= 2'h0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
      arb_lost_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      nack_o <= 1'b0;
      arb_lost_o <= 1'b0;
      data_o <= ~data_o;
      if (!req_i || done_o) begin
        wait_cnt <= 3'h0;
      end else if (wait_cnt == (slow_i ? 3'h4 : 3'h0)) begin
        wait_cnt <= 3'h0;
        done_o <= 1'b1;
        data_o <= mem[offset_i[7:0]] ^ ((bad_crc_i && offset_i == 15'h84) ? 8'hFF : 8'h00);
        // Refuse one byte in the register area so the abort leaves a partial load
        nack_o <= nack_i && offset_i == 15'h10;
        if (offset_i == 15'h0 && lost < arb_loss_i) begin
          lost <= lost + 2'h1;
          arb_lost_o <= 1'b1;
        end
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule // boot_memory_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
  import startup_boot_pkg::*;
  logic clk_i, rst_i, por_done_i, reg_wr_i, reg_rd_i, reg_ready_o, mst_req_o, mst_wide_o;
  logic mst_fast_o, mst_done_i, mst_nack_i, mst_arb_lost_i, load_wr_o, otp_full_load_o;
  logic boot_busy_o, boot_failure_flag_o, slow, bad, nak;
  logic [1:0] loss;
  logic [6:0] mst_dev_addr_o;
  logic [9:0] reg_addr_i;
  logic [10:0] otp_config_code_i;
  logic [14:0] mst_offset_o;
  logic [7:0] otp_startup0_i, otp_startup1_i, gpi_status_i, global_status_i, reg_wdata_i;
  logic [7:0] reg_rdata_o, mst_data_i, load_addr_o, load_data_o, int_enable_o;
  logic [15:0] nload, last_load;
  int n_fail = 0;
  int checked = 0;

  startup_boot_and_id_registers dut (.*);
  boot_memory_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mst_req_o),
    .offset_i(mst_offset_o), .slow_i(slow), .bad_crc_i(bad), .arb_loss_i(loss), .nack_i(nak),
    .done_o(mst_done_i), .nack_o(mst_nack_i), .arb_lost_o(mst_arb_lost_i), .data_o(mst_data_i));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Count bytes pushed into the device registers
  always @(posedge clk_i) begin
    if (rst_i) nload <= 16'h0000;
    else if (load_wr_o === 1'b1) begin
      nload <= nload + 16'h0001;
      last_load <= {load_addr_o, load_data_o};
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Accesses start and end on falling edges, one idle cycle after each
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("reg_rdata_o", {8'h00, exp}, {8'h00, reg_rdata_o});
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Reset, hold power-up pending a while, then wait for the slave port
  task automatic boot(input logic [7:0] s0, input logic [7:0] s1, input logic sl,
                      input logic bc, input logic [1:0] al);
    otp_startup0_i = s0;
    otp_startup1_i = s1;
    slow = sl;
    bad = bc;
    loss = al;
    por_done_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("boot_busy_o", 16'h0001, {15'h0, boot_busy_o});
    por_done_i = 1'b1;
    for (int i = 0; i < 2000 && reg_ready_o !== 1'b1; i++) @(negedge clk_i);
    if (reg_ready_o !== 1'b1) begin
      n_fail++;
      $display("Error reg_ready_o expected 1 seen %b", reg_ready_o);
      tally_and_finish();
    end
  endtask

  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    nak = 1'b0;
    otp_config_code_i = 11'h5E7;
    gpi_status_i = 8'h3C;
    global_status_i = 8'hA4;
    // Internal boot only; reserved bit 2 set in the image
    boot(8'h05, 8'h9B, 1'b0, 1'b0, 2'h0);
    chk("otp_full_load_o", 16'h0001, {15'h0, otp_full_load_o});
    rd(OFF_BOOT_RETRY_SOURCE, 8'h09);
    rd(OFF_EEPROM_TARGET, 8'h9B);
    chk("mst_wide_o", 16'h0001, {15'h0, mst_wide_o});
    rd(OFF_REV_PART_HIGH, 8'h5A);
    rd(OFF_PART_MIDDLE, 8'h5C);
    rd(OFF_PART_LOW_CFG_HIGH, 8'h3B);
    rd(OFF_CFG_LOW, 8'h67);
    wr(OFF_CFG_LOW, 8'h12);
    rd(OFF_CFG_LOW, 8'h12);
    wr(10'h3FF, 8'h55);
    rd(10'h3FF, 8'h00);
    rd(OFF_GPI_STATUS, 8'h3C);
    wr(OFF_INT_ENABLE, 8'hC3);
    rd(OFF_INT_ENABLE, 8'hC3);
    chk("int_enable_o", 16'h00C3, {8'h00, int_enable_o});
    rd(OFF_GLOBAL_STATUS, 8'hA6);
    wr(OFF_BOOT_RETRY_SOURCE, 8'hFA);
    rd(OFF_BOOT_RETRY_SOURCE, 8'hFA);
    // Enabling external boot late must not start a load
    chk("mst_req_o", 16'h0000, {15'h0, mst_req_o});
    chk("boot_busy_o", 16'h0000, {15'h0, boot_busy_o});
    wr(OFF_EEPROM_TARGET, 8'h00);
    chk("mst_wide_o", 16'h0000, {15'h0, mst_wide_o});
    wr(OFF_EEPROM_TARGET, 8'h80);
    rd(OFF_EEPROM_TARGET, 8'h80);
    // External boot from a slow memory with a good image
    boot(8'h02, 8'h50, 1'b1, 1'b0, 2'h0);
    chk("otp_full_load_o", 16'h0000, {15'h0, otp_full_load_o});
    chk("nload", 16'h007C, nload);
    chk("last_load", 16'h83D9, last_load);
    chk("mst_dev_addr_o", 16'h0050, {9'h0, mst_dev_addr_o});
    chk("mst_fast_o", 16'h0001, {15'h0, mst_fast_o});
    rd(OFF_GLOBAL_STATUS, 8'hA6);
    // Corrupt checksum, then clear the flag
    boot(8'h00, 8'h50, 1'b0, 1'b1, 2'h0);
    rd(OFF_GLOBAL_STATUS, 8'hA7);
    wr(OFF_GLOBAL_STATUS, 8'h01);
    rd(OFF_GLOBAL_STATUS, 8'hA6);
    // One lost arbitration is retried, two exhaust the default count
    boot(8'h00, 8'h50, 1'b0, 1'b0, 2'h1);
    chk("boot_failure_flag_o", 16'h0000, {15'h0, boot_failure_flag_o});
    boot(8'h00, 8'h50, 1'b0, 1'b0, 2'h2);
    chk("boot_failure_flag_o", 16'h0001, {15'h0, boot_failure_flag_o});
    chk("nload", 16'h0000, nload);
    // A refused byte mid-image aborts; bytes before it stay loaded
    nak = 1'b1;
    boot(8'h00, 8'h50, 1'b0, 1'b0, 2'h0);
    chk("boot_failure_flag_o", 16'h0001, {15'h0, boot_failure_flag_o});
    chk("nload", 16'h0008, nload);
    chk("last_load", 16'h0F55, last_load);
    tally_and_finish();
  end
endmodule // testbench
